/* File: hdl/lpm_ctrl.sv */
// Operating mode controller: STOP and IDLE entry, wake and warm-up
// Function
// RL1: Stop bit 7 write enters STOP
// RL2: STOP gates oscillator and halts all
// RL3: Hold state; port_out_keep selects hold/Hi-Z
// RL4: Divider cleared on STOP entry
// RL5: PC kept at next instruction
// RL6: release_method_sel: 1 level, 0 edge
// RL7: Level mode wakes on pin high
// RL8: Level mode, pin high skips stop
// RL9: Warm-up never returns to STOP
// RL10: Edge to level waits for edge
// RL11: Edge mode wakes on rising edge
// RL12: Edge mode stops despite pin high
// RL13: Restart oscillator, then halted warm-up
// RL14: warmup_sel chooses warm-up length
// RL15: Warm-up counted by timing divider
// RL16: Clear divider, resume after warm-up
// RL17: Reset ends modes, back to NORMAL
// RL18: Idle bit 4 halts CPU, watchdog
// RL19: IDLE holds state and PC
// RL20: MASTER_IRQ_ENABLE zero: enabled irq resumes next
// RL21: MASTER_IRQ_ENABLE one: enabled irq gets serviced
// RL22: Watchdog irq just before blocks IDLE
// RL23: 00 three x 2^19, 01 2^19
// RL24: Stop pin synchronised, edge detected
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module lpm_ctrl #(
   parameter int unsigned WARM_SHORT_CYC = 1 << lpm_pkg::WARM_EXP,
   parameter int unsigned WARM_LONG_CYC =
      lpm_pkg::WARM_LONG_MUL * (1 << lpm_pkg::WARM_EXP)
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic stop_pin,
   input wire logic irq_enabled_req,
   input wire logic wdt_irq_req,
   output logic osc_enable,
   output logic cpu_halt,
   output logic wdt_halt,
   output logic periph_halt,
   output logic port_hiz,
   output logic div_clear,
   output logic irq_service,
   output logic resume_next
);
   localparam int DIV_W_L = lpm_pkg::DIV_W;
   lpm_pkg::lpm_mode_t mode_q, mode_d;
   logic [7:0] one_q, one_d, two_q, two_d;
   logic imf_q, imf_d;
   logic release_method_sel_eff_q, release_method_sel_eff_d;
   logic [31:0] cnt_q, cnt_d;
   logic [DIV_W_L-1:0] div_q, div_d;
   logic ap_wr_q, ap_wr_d, ap_rd_q, ap_rd_d;
   logic [7:0] ap_ofs_q, ap_ofs_d;
   logic [31:0] rdata_q, rdata_d;
   logic svc_q, svc_d, res_q, res_d;
   logic pin_lvl, pin_rise, ap_ok;
   logic stop_go, idle_go, wake;

   // Stop pin sampled with edge detect
   // RL24: synchronise stop pin
   lpm_sync u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .pin(stop_pin),
      .level(pin_lvl),
      .rise(pin_rise)
   );

   assign ap_ok = hsel & hready & (htrans == lpm_pkg::HTRANS_NONSEQ);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   always_comb begin
      mode_d = mode_q;
      one_d = one_q;
      two_d = two_q;
      imf_d = imf_q;
      release_method_sel_eff_d = release_method_sel_eff_q;
      cnt_d = cnt_q;
      div_d = div_q + 1'b1;
      ap_wr_d = ap_ok & hwrite;
      ap_rd_d = ap_ok & ~hwrite;
      ap_ofs_d = ap_ok ? haddr[7:0] : ap_ofs_q;
      rdata_d = rdata_q;
      svc_d = 1'b0;
      res_d = 1'b0;
      stop_go = 1'b0;
      idle_go = 1'b0;
      wake = 1'b0;
      // Bus read data for next data phase
      if (ap_ok && !hwrite) begin
         unique case (haddr[7:0])
            lpm_pkg::OFS_SYS_ONE: rdata_d = {24'h000000, one_q[7:2], 2'h0};
            lpm_pkg::OFS_SYS_TWO:
               rdata_d = {24'h000000, two_q | lpm_pkg::SYS_TWO_RO};
            lpm_pkg::OFS_STATUS:
               rdata_d = {29'h00000000, pin_lvl, mode_q[1:0]};
            lpm_pkg::OFS_IRQ: rdata_d = {31'h00000000, imf_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
      if (ap_wr_q) begin
         unique case (ap_ofs_q)
            lpm_pkg::OFS_SYS_ONE: begin
               one_d = hwdata[7:0];
               // RL1: stop bit starts STOP
               stop_go = hwdata[lpm_pkg::B_STOP];
               // RL10: edge to level waits for edge
               if (!hwdata[lpm_pkg::B_RELEASE_METHOD_SEL]) begin
                  release_method_sel_eff_d = 1'b0;
               end
            end
            lpm_pkg::OFS_SYS_TWO: begin
               two_d = {1'b1, 2'h0, hwdata[4], 4'h0};
               // RL18: idle bit starts IDLE
               idle_go = hwdata[lpm_pkg::B_IDLE];
            end
            lpm_pkg::OFS_IRQ: imf_d = hwdata[lpm_pkg::B_IMF];
            default: ;
         endcase
      end
      if (one_q[lpm_pkg::B_RELEASE_METHOD_SEL] && pin_rise) begin
         release_method_sel_eff_d = 1'b1;
      end
      unique case (mode_q)
         lpm_pkg::LPM_NORMAL: begin
            if (stop_go) begin
               // RL4: divider cleared on entry
               div_d = '0;
               // RL8: level mode with pin high
               if (release_method_sel_eff_d && pin_lvl) begin
                  mode_d = lpm_pkg::LPM_WARM;
               end else begin
                  // RL12: edge mode stops anyway
                  mode_d = lpm_pkg::LPM_STOP;
               end
               // RL14: warm-up length select
               // RL23: long or short encoding
               cnt_d = (hwdata[lpm_pkg::B_WUT_HI:lpm_pkg::B_WUT_LO]
                        == lpm_pkg::WUT_SHORT) ?
                       WARM_SHORT_CYC : WARM_LONG_CYC;
            end else if (idle_go) begin
               // RL22: watchdog irq blocks IDLE
               if (wdt_irq_req) begin
                  svc_d = 1'b1;
                  two_d[lpm_pkg::B_IDLE] = 1'b0;
               end else begin
                  mode_d = lpm_pkg::LPM_IDLE;
               end
            end
         end
         lpm_pkg::LPM_STOP: begin
            // RL2: everything frozen
            div_d = '0;
            // RL6: release method select
            // RL7: level wake
            // RL11: edge wake
            wake = release_method_sel_eff_q ? pin_lvl : pin_rise;
            if (wake) begin
               // RL13: oscillator back, warm-up
               mode_d = lpm_pkg::LPM_WARM;
            end
         end
         lpm_pkg::LPM_WARM: begin
            // RL9: pin low cannot restop
            // RL15: counted on the divider clock
            if (cnt_q <= 32'd1) begin
               // RL16: clear divider and resume
               div_d = '0;
               mode_d = lpm_pkg::LPM_NORMAL;
               one_d[lpm_pkg::B_STOP] = 1'b0;
               res_d = 1'b1;
            end else begin
               cnt_d = cnt_q - 32'd1;
            end
         end
         lpm_pkg::LPM_IDLE: begin
            if (irq_enabled_req || wdt_irq_req) begin
               mode_d = lpm_pkg::LPM_NORMAL;
               two_d[lpm_pkg::B_IDLE] = 1'b0;
               // RL21: serviced when MASTER_IRQ_ENABLE set
               // RL20: else resume next, unless wdt_irq_req is set
               svc_d = imf_q | wdt_irq_req;
               res_d = ~(imf_q | wdt_irq_req);
            end
         end
         default: mode_d = lpm_pkg::LPM_NORMAL;
      endcase
   end

   // RL17: reset forces NORMAL
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= lpm_pkg::LPM_NORMAL;
         one_q <= lpm_pkg::SYS_ONE_RST;
         two_q <= lpm_pkg::SYS_TWO_RST;
         imf_q <= 1'b0;
         release_method_sel_eff_q <= 1'b0;
         cnt_q <= 32'h00000000;
         div_q <= '0;
         ap_wr_q <= 1'b0;
         ap_rd_q <= 1'b0;
         ap_ofs_q <= 8'h00;
         rdata_q <= 32'h00000000;
         svc_q <= 1'b0;
         res_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         one_q <= one_d;
         two_q <= two_d;
         imf_q <= imf_d;
         release_method_sel_eff_q <= release_method_sel_eff_d;
         cnt_q <= cnt_d;
         div_q <= div_d;
         ap_wr_q <= ap_wr_d;
         ap_rd_q <= ap_rd_d;
         ap_ofs_q <= ap_ofs_d;
         rdata_q <= rdata_d;
         svc_q <= svc_d;
         res_q <= res_d;
      end
   end

   // RL2: oscillator off only in STOP
   assign osc_enable = (mode_q != lpm_pkg::LPM_STOP);
   // RL5: CPU halted in STOP and warm-up
   // RL19: CPU halted in IDLE, state held
   assign cpu_halt = (mode_q != lpm_pkg::LPM_NORMAL);
   assign wdt_halt = (mode_q != lpm_pkg::LPM_NORMAL);
   assign periph_halt = (mode_q == lpm_pkg::LPM_STOP) ||
                        (mode_q == lpm_pkg::LPM_WARM);
   // RL3: Hi-Z unless port_out_keep
   assign port_hiz = periph_halt & ~one_q[lpm_pkg::B_KEEP];
   assign div_clear = (div_q == '0) && (mode_q != lpm_pkg::LPM_IDLE);
   assign irq_service = svc_q;
   assign resume_next = res_q;
endmodule

/* File: hdl/lpm_pkg.sv */
// Package: offsets, fields, reset values and timing for the mode controller
package lpm_pkg;
   // Register byte offsets on the AHB-Lite bus
   localparam logic [7:0] OFS_SYS_ONE = 8'h00;
   localparam logic [7:0] OFS_SYS_TWO = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ = 8'h0C;
   // system_control_one fields
   localparam int B_STOP = 7;
   localparam int B_RELEASE_METHOD_SEL = 6;
   localparam int B_KEEP = 4;
   localparam int B_WUT_HI = 3;
   localparam int B_WUT_LO = 2;
   // system_control_two fields
   localparam int B_IDLE = 4;
   localparam logic [7:0] SYS_ONE_RST = 8'h00;
   localparam logic [7:0] SYS_TWO_RST = 8'h80;
   localparam logic [7:0] SYS_TWO_RO = 8'h0F;
   // irq register fields
   localparam int B_IMF = 0;
   localparam int B_WDT = 1;
   // Warm-up lengths in oscillator periods
   localparam int WARM_EXP = 19;
   localparam int WARM_LONG_MUL = 3;
   localparam logic [1:0] WUT_LONG = 2'h0;
   localparam logic [1:0] WUT_SHORT = 2'h1;
   localparam int DIV_W = 21;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [2:0] {
      LPM_NORMAL, LPM_STOP, LPM_WARM, LPM_IDLE
   } lpm_mode_t;
endpackage

/* File: hdl/lpm_sync.sv */
// Three-stage synchroniser with agreement filter and rising edge detect
`timescale 1ns/1ps
module lpm_sync (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pin,
   output logic level,
   output logic rise
);
   logic s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_q, rise_d;
   always_comb begin
      lvl_d = lvl_q;
      if (s2_q == s3_q) begin
         lvl_d = s2_q;
      end
      rise_d = lvl_d & ~lvl_q;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
         rise_q <= rise_d;
      end
   end
   assign level = lvl_q;
   assign rise = rise_q;
endmodule

/* File: testbench/low_power_mode_control_bench.sv */
// Self-checking bench for the mode controller
`timescale 1ns/1ps
`define CHK(s, e, a) begin checks_done++; if ((a) !== (e)) begin \
   error_cnt++; $display("Error %s exp %h got %h", s, e, a); end end
module low_power_mode_control_bench;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic irq_enabled_req = 1'b0;
   logic wdt_irq_req = 1'b0;
   logic pin_req = 1'b0;
   logic [7:0] pin_dly = 8'h00;
   logic [31:0] hrdata, r;
   logic hreadyout, hresp, stop_pin, osc_enable, cpu_halt, wdt_halt;
   logic periph_halt, port_hiz, div_clear, irq_service, resume_next;
   int error_cnt = 0;
   int checks_done = 0;
   int n;
   always #50 clk = ~clk;
   lpm_ctrl #(.WARM_SHORT_CYC(8), .WARM_LONG_CYC(24)) i_dut (
      .clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .stop_pin,
      .irq_enabled_req, .wdt_irq_req, .osc_enable, .cpu_halt, .wdt_halt,
      .periph_halt, .port_hiz, .div_clear, .irq_service, .resume_next);
   lpm_wake_src i_src (.clk, .level_req(pin_req), .delay(pin_dly), .stop_pin);
   task ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= lpm_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task pin(input logic l, input logic [7:0] d);
      @(posedge clk);
      pin_req <= l;
      pin_dly <= d;
   endtask
   task wp(input logic s);
      n = 0;
      while (!(s ? irq_service : resume_next) && n < 99) begin
         @(negedge clk);
         n++;
      end
   endtask
   task t_edge;
      pin(1'b1, 8'h00);
      repeat (8) @(posedge clk);
      ahb(lpm_pkg::OFS_SYS_ONE, 1'b1, 32'h84);
      repeat (2) @(posedge clk);
      `CHK("osc", 1'b0, osc_enable)
      `CHK("hiz", 1'b1, port_hiz)
      `CHK("div", 1'b1, div_clear)
      pin(1'b0, 8'h00);
      repeat (8) @(posedge clk);
      pin(1'b1, 8'h09);
      wp(1'b0);
      `CHK("resume", 1'b1, resume_next)
      ahb(lpm_pkg::OFS_STATUS, 1'b0, 32'h0);
      `CHK("status", 32'h4, r)
      ahb(lpm_pkg::OFS_SYS_ONE, 1'b0, 32'h0);
      `CHK("sys_one", 32'h04, r)
   endtask
   task t_level;
      ahb(lpm_pkg::OFS_SYS_ONE, 1'b1, 32'hC4);
      repeat (2) @(posedge clk);
      `CHK("osc", 1'b0, osc_enable)
      pin(1'b0, 8'h00);
      repeat (8) @(posedge clk);
      pin(1'b1, 8'h00);
      wp(1'b0);
      `CHK("resume", 1'b1, resume_next)
      ahb(lpm_pkg::OFS_SYS_ONE, 1'b1, 32'hD4);
      repeat (2) @(posedge clk);
      `CHK("osc", 1'b1, osc_enable)
      `CHK("warm", 1'b1, periph_halt)
      `CHK("hiz", 1'b0, port_hiz)
      pin(1'b0, 8'h00);
      wp(1'b0);
      `CHK("resume", 1'b1, resume_next)
      repeat (8) @(posedge clk);
      ahb(lpm_pkg::OFS_SYS_ONE, 1'b1, 32'hC0);
      repeat (2) @(posedge clk);
      `CHK("osc", 1'b0, osc_enable)
      pin(1'b1, 8'h00);
      wp(1'b0);
      `CHK("resume", 1'b1, resume_next)
      `CHK("long", 1'b1, n >= 24)
   endtask
   task t_idle;
      ahb(lpm_pkg::OFS_SYS_TWO, 1'b1, 32'h90);
      repeat (2) @(posedge clk);
      `CHK("cpu", 1'b1, cpu_halt)
      `CHK("periph", 1'b0, periph_halt)
      irq_enabled_req <= 1'b1;
      wp(1'b0);
      `CHK("resume", 1'b1, resume_next)
      `CHK("service", 1'b0, irq_service)
      irq_enabled_req <= 1'b0;
      ahb(lpm_pkg::OFS_IRQ, 1'b1, 32'h1);
      ahb(lpm_pkg::OFS_SYS_TWO, 1'b1, 32'h90);
      repeat (2) @(posedge clk);
      irq_enabled_req <= 1'b1;
      wp(1'b1);
      `CHK("service", 1'b1, irq_service)
      irq_enabled_req <= 1'b0;
      wdt_irq_req <= 1'b1;
      ahb(lpm_pkg::OFS_SYS_TWO, 1'b1, 32'h90);
      repeat (2) @(posedge clk);
      `CHK("cpu", 1'b0, cpu_halt)
      wdt_irq_req <= 1'b0;
   endtask
   task t_reset;
      ahb(lpm_pkg::OFS_SYS_ONE, 1'b1, 32'h84);
      repeat (2) @(posedge clk);
      arst_n <= 1'b0;
      @(posedge clk);
      `CHK("osc", 1'b1, osc_enable)
      `CHK("cpu", 1'b0, cpu_halt)
      arst_n <= 1'b1;
      ahb(lpm_pkg::OFS_SYS_TWO, 1'b0, 32'h0);
      `CHK("sys_two", 32'h8F, r)
      ahb(8'h10, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, r)
   endtask
   task end_of_test;
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      error_cnt++;
      end_of_test;
   end
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_edge;
      t_level;
      t_idle;
      t_reset;
      end_of_test;
   end
endmodule

/* File: testbench/lpm_ctrl_monitor.sv */
// Port checker for the mode controller
`timescale 1ns/1ps
module lpm_ctrl_monitor #(
   parameter int unsigned WARM_SHORT_CYC = 8
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic osc_enable,
   input wire logic cpu_halt,
   input wire logic wdt_halt,
   input wire logic periph_halt,
   input wire logic port_hiz,
   input wire logic div_clear,
   input wire logic irq_service,
   input wire logic resume_next
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   int unsigned warm_q;
   // Length of the current warm-up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         warm_q <= 0;
      end else begin
         warm_q <= (osc_enable && periph_halt) ? warm_q + 1 : 0;
      end
   end
   property p_osc; !osc_enable |-> periph_halt && cpu_halt && wdt_halt;
   endproperty
   property p_hiz; port_hiz |-> periph_halt; endproperty
   property p_div; $fell(osc_enable) |-> div_clear; endproperty
   property p_rst; $rose(osc_enable) |-> periph_halt; endproperty
   property p_warm; $fell(periph_halt) |-> warm_q >= WARM_SHORT_CYC;
   endproperty
   property p_res; $fell(periph_halt) |-> resume_next || $past(resume_next);
   endproperty
   property p_idl; cpu_halt && !periph_halt |-> wdt_halt && osc_enable;
   endproperty
   property p_one; resume_next |-> !irq_service ##1 !resume_next;
   endproperty
   property p_svc; irq_service |=> !cpu_halt; endproperty
   a_osc: assert property (p_osc) else $error("stop not halting");
   a_hiz: assert property (p_hiz) else $error("pins float early");
   a_div: assert property (p_div) else $error("divider not clear");
   a_rst: assert property (p_rst) else $error("no warm-up");
   a_warm: assert property (p_warm) else $error("warm-up short");
   a_res: assert property (p_res) else $error("no resume");
   a_idl: assert property (p_idl) else $error("idle state wrong");
   a_one: assert property (p_one) else $error("resume pulse bad");
   a_svc: assert property (p_svc) else $error("service no exit");
   c_stop: cover property ($fell(osc_enable));
   c_res: cover property (resume_next);
   c_svc: cover property (irq_service);
endmodule
bind lpm_ctrl lpm_ctrl_monitor #(.WARM_SHORT_CYC(WARM_SHORT_CYC)) i_mon (
   .clk, .arst_n, .osc_enable, .cpu_halt, .wdt_halt, .periph_halt,
   .port_hiz, .div_clear, .irq_service, .resume_next);

/* File: testbench/lpm_wake_src.sv */
// Wake pin source: moves the stop pin after a set delay
`timescale 1ns/1ps
module lpm_wake_src (
   input wire logic clk,
   input wire logic level_req,
   input wire logic [7:0] delay,
   output logic stop_pin
);
   logic [7:0] cnt_q = 8'h00;
   initial stop_pin = 1'b0;
   always @(posedge clk) begin
      if (level_req == stop_pin) begin
         cnt_q <= 8'h00;
      end else if (cnt_q >= delay) begin
         stop_pin <= level_req;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule
